// ==== design/ohs_consts.svh ====
// Offsets, field positions, reset values and timing counts of the host select block.
// Assumes inclusion by bare name from design files and the checker.
`ifndef OHS_CONSTS_SVH
`define OHS_CONSTS_SVH

// Clock rate and host reset pulse
`define OHS_CLK_MHZ 100
`define OHS_RST_MIN_NS 40
`define OHS_RST_MIN_CYC ((`OHS_RST_MIN_NS * `OHS_CLK_MHZ + 999) / 1000)

// Channel register offsets (A3:A0 with A7 low)
`define OHS_CH_DATA 4'h0
`define OHS_CH_FCR 4'h2
`define OHS_CH_MCR 4'h4

// Channel register fields
`define OHS_MCR_IR_BIT 6
`define OHS_MCR_PRE_BIT 7
`define OHS_FCR_EN_BIT 0
`define OHS_FCR_RXCLR_BIT 1
`define OHS_FCR_TXCLR_BIT 2

// Global register offsets (A3:A0 with A7 high)
`define OHS_G_INT0 4'h0
`define OHS_G_INT1 4'h1
`define OHS_G_INT2 4'h2
`define OHS_G_INT3 4'h3
`define OHS_G_TCTL 4'h4
`define OHS_G_TLO 4'h6
`define OHS_G_THI 4'h7
`define OHS_G_BCAST 4'h8
`define OHS_G_RESET 4'h9

// Global register fields
`define OHS_BCAST_BIT 0
`define OHS_TCTL_RUN_BIT 0
`define OHS_TCTL_EXT_BIT 1

// Reset values
`define OHS_MCR_RST 8'h00
`define OHS_FCR_RST 8'h00
`define OHS_TLOAD_RST 16'h0000

// FIFO trigger levels and prescaler terminal count
`define OHS_TRIG_L0 5'h01
`define OHS_TRIG_L1 5'h04
`define OHS_TRIG_L2 5'h08
`define OHS_TRIG_L3 5'h0E
`define OHS_PRE_LAST 2'h3

`endif

// ==== design/ohs_fifo.sv ====
// Byte FIFO with registered head word (first word falls through).
// Assumes push is refused when full and pop is ignored when empty.
`timescale 1ns/1ps
`default_nettype none
module ohs_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clr_i,
   input wire logic push_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic pop_i,
   output logic [W-1:0] rdata_o,
   output logic valid_o,
   output logic full_o,
   output logic [AW:0] count_o
);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] count_q, count_d;
   logic [W-1:0] rdata_q, rdata_d;
   logic valid_q;
   wire logic do_push, do_pop, to_head;
   wire logic [AW-1:0] rd_nx;

   // Accept, occupancy and next head word
   assign do_push = push_i & (count_q != FULL_CNT);
   assign do_pop = pop_i & (count_q != '0);
   assign rd_nx = rd_q + 1'b1;
   assign to_head = do_push & ((count_q == '0) | ((count_q == (AW+1)'(1)) & do_pop));
   assign count_d = (do_push & ~do_pop) ? count_q + 1'b1 :
                    (do_pop & ~do_push) ? count_q - 1'b1 : count_q;
   assign rdata_d = to_head ? wdata_i : (do_pop ? mem_q[rd_nx] : rdata_q);

   // Storage array, no reset needed
   always_ff @(posedge clk_i)
   begin
      if (do_push)
      begin
         mem_q[wr_q] <= wdata_i;
      end
   end

   // Pointers, count and head register
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
         rdata_q <= '0;
         valid_q <= 1'b0;
      end
      else if (clr_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
         valid_q <= 1'b0;
      end
      else
      begin
         wr_q <= do_push ? wr_q + 1'b1 : wr_q;
         rd_q <= do_pop ? rd_nx : rd_q;
         count_q <= count_d;
         rdata_q <= rdata_d;
         valid_q <= (count_d != '0); // Not empty, kept in a flop for the output
      end
   end

   assign rdata_o = rdata_q;
   assign valid_o = valid_q;
   assign full_o = (count_q == FULL_CNT);
   assign count_o = count_q;
endmodule : ohs_fifo
`default_nettype wire

// ==== design/ohs_host_select.sv ====
// Host bus port of the eight channel serial device: channel decode, broadcast
// write, global registers, resets, infrared start-up, FIFOs, prescalers, timer.
// Assumes all pins but timer_ext_clock_i synchronous to sys_clk_i; channel cores sit outside.
//
// Behaviour
// R1: Sample infrared pin into every modem control bit6
// R2: Host must pulse reset at power-up
// R3: Hardware reset clears registers and serial outputs
// R4: Host holds reset low over 40 ns
// R5: Writing reset register resets every channel
// R6: Chip select low needed; high ignores cycles
// R7: A7 low: A6:A4 picks one channel
// R8: Broadcast bit makes writes hit all channels
// R9: Host uses broadcast carefully on active channels
// R10: Style pin picks strobe or enable bus
// R11: Four interrupt source registers in global space
// R12: Sixteen byte FIFOs each way, programmable triggers
// R13: Baud prescaler divides clock by 1 or 4
// R14: Sixteen bit timer with external clock input
// R15: A7 high selects global registers by A3:A0
`include "ohs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ohs_host_select #(
   parameter int NCH = 8,
   parameter int FIFO_DEPTH = 16,
   parameter int TMR_W = 16
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic bus_style_i,
   input wire logic cs_n_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic [7:0] addr_i,
   input wire ohs_pkg::ohs_byte_t data_i,
   output ohs_pkg::ohs_byte_t data_o,
   output logic data_oe_n_o,
   input wire logic infrared_startup_pin_i,
   input wire logic timer_ext_clock_i,
   input wire logic sleep_wake_i,
   input wire logic [NCH-1:0] chan_irq_i,
   input wire logic [2*NCH-1:0] chan_irq_code_i,
   input wire logic [8*NCH-1:0] chan_rd_data_i,
   output logic [NCH-1:0] chan_wr_o,
   output logic [NCH-1:0] chan_rd_o,
   output logic [3:0] chan_reg_o,
   output ohs_pkg::ohs_byte_t chan_wdata_o,
   output logic chan_soft_reset_o,
   output logic [NCH-1:0] ir_mode_o,
   output logic [NCH-1:0] baud_tick_o,
   output logic [8*NCH-1:0] tx_data_o,
   output logic [NCH-1:0] tx_valid_o,
   input wire logic [NCH-1:0] tx_pop_i,
   input wire logic [NCH-1:0] rx_push_i,
   input wire logic [8*NCH-1:0] rx_data_i,
   output logic [NCH-1:0] rx_full_o,
   output logic [NCH-1:0] tx_trig_o,
   output logic [NCH-1:0] rx_trig_o
);
   import ohs_pkg::*;

   localparam int CAW = $clog2(FIFO_DEPTH);

   // One-hot channel decode
   function automatic logic [NCH-1:0] ohs_onehot(input logic [2:0] ch);
      ohs_onehot = '0;
      ohs_onehot[ch] = 1'b1;
   endfunction : ohs_onehot

   // Trigger level from a two bit FIFO control field
   function automatic logic [CAW:0] ohs_trig(input logic [1:0] sel);
      logic [4:0] lvl;
      lvl = (sel == 2'h0) ? `OHS_TRIG_L0 : (sel == 2'h1) ? `OHS_TRIG_L1 :
            (sel == 2'h2) ? `OHS_TRIG_L2 : `OHS_TRIG_L3;
      ohs_trig = (CAW+1)'(lvl);
   endfunction : ohs_trig

   ohs_acc_t acc_q, acc_d;
   ohs_byte_t data_q, chan_wdata_q;
   logic oe_n_q, bcast_q, soft_rst_q, ir_load_q, tmr_flag_q;
   logic [1:0] tctl_q;
   logic [TMR_W-1:0] tload_q;
   logic [NCH-1:0] chan_wr_q, chan_rd_q;
   logic [3:0] chan_reg_q;
   wire logic rd_lvl, wr_lvl, rd_start, wr_start, is_glob;
   wire logic g_wr, int1_rd, tmr_load, tmr_expire;
   wire logic [2:0] ch_sel;
   wire logic [3:0] reg_sel;
   wire logic [NCH-1:0] wr_vec, rd_vec;
   wire logic [TMR_W-1:0] tmr_count;
   wire ohs_byte_t glob_rdata, ch_rdata, int1_val, int2_val, int3_val;
   wire logic [8*NCH-1:0] mcr_all, rx_head_all;

   // Bus style: strobe pins, or chip select as enable with write pin as read/write
   assign rd_lvl = ~cs_n_i & (bus_style_i ? ~read_strobe_n_i : write_strobe_n_i); // [R6] [R10]
   assign wr_lvl = ~cs_n_i & ~write_strobe_n_i; // [R6] [R10]
   assign rd_start = (acc_q == OHS_IDLE) & rd_lvl;
   assign wr_start = (acc_q == OHS_IDLE) & wr_lvl & ~rd_lvl;

   // Address split into space, channel and register
   assign is_glob = addr_i[7]; // [R15]
   assign ch_sel = addr_i[6:4]; // [R7]
   assign reg_sel = addr_i[3:0];
   assign wr_vec = (wr_start & ~is_glob) ?
                   (bcast_q ? {NCH{1'b1}} : ohs_onehot(ch_sel)) : '0; // [R7] [R8]
   assign rd_vec = (rd_start & ~is_glob) ? ohs_onehot(ch_sel) : '0; // [R7] [R8]

   // Global register strobes
   assign g_wr = wr_start & is_glob; // [R15]
   assign int1_rd = rd_start & is_glob & (reg_sel == `OHS_G_INT1);
   assign tmr_load = g_wr & (reg_sel == `OHS_G_THI);

   // Interrupt source summary
   assign int1_val = {6'h00, sleep_wake_i, tmr_flag_q}; // [R11]
   assign int2_val = chan_irq_code_i[7:0]; // [R11]
   assign int3_val = chan_irq_code_i[15:8]; // [R11]

   // Global read selection
   assign glob_rdata = (reg_sel == `OHS_G_INT0) ? chan_irq_i[7:0] :
                       (reg_sel == `OHS_G_INT1) ? int1_val :
                       (reg_sel == `OHS_G_INT2) ? int2_val :
                       (reg_sel == `OHS_G_INT3) ? int3_val :
                       (reg_sel == `OHS_G_TCTL) ? {6'h00, tctl_q} :
                       (reg_sel == `OHS_G_TLO) ? tmr_count[7:0] :
                       (reg_sel == `OHS_G_THI) ? tmr_count[15:8] :
                       (reg_sel == `OHS_G_BCAST) ? {7'h00, bcast_q} : 8'h00; // [R15]

   // Channel read selection, other offsets come from the channel core
   assign ch_rdata = (reg_sel == `OHS_CH_DATA) ? rx_head_all[{ch_sel, 3'h0} +: 8] :
                     (reg_sel == `OHS_CH_MCR) ? mcr_all[{ch_sel, 3'h0} +: 8] :
                     chan_rd_data_i[{ch_sel, 3'h0} +: 8]; // [R7]

   // Access tracker: one action per strobe assertion
   always_comb
   begin
      acc_d = acc_q;
      case (acc_q)
         OHS_IDLE: acc_d = rd_lvl ? OHS_RD : (wr_lvl ? OHS_WR : OHS_IDLE);
         OHS_RD: acc_d = rd_lvl ? OHS_RD : OHS_IDLE;
         OHS_WR: acc_d = wr_lvl ? OHS_WR : OHS_IDLE;
         default: acc_d = OHS_IDLE;
      endcase
   end

   // Bus side registers and channel strobes
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         acc_q <= OHS_IDLE;
         data_q <= 8'h00;
         oe_n_q <= 1'b1;
         chan_wr_q <= '0;
         chan_rd_q <= '0;
         chan_reg_q <= 4'h0;
         chan_wdata_q <= 8'h00;
      end
      else
      begin
         acc_q <= acc_d;
         data_q <= rd_start ? (is_glob ? glob_rdata : ch_rdata) : data_q;
         oe_n_q <= ~(acc_d == OHS_RD); // [R6]
         chan_wr_q <= wr_vec;
         chan_rd_q <= rd_vec;
         chan_reg_q <= (rd_start | wr_start) ? reg_sel : chan_reg_q;
         chan_wdata_q <= wr_start ? data_i : chan_wdata_q;
      end
   end

   // Global configuration registers, soft reset and infrared sampling
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         bcast_q <= 1'b0; // [R3]
         tctl_q <= 2'h0;
         tload_q <= `OHS_TLOAD_RST;
         soft_rst_q <= 1'b0;
         ir_load_q <= 1'b1; // [R1]
         tmr_flag_q <= 1'b0;
      end
      else
      begin
         soft_rst_q <= g_wr & (reg_sel == `OHS_G_RESET); // [R5]
         ir_load_q <= soft_rst_q; // [R1]
         tmr_flag_q <= tmr_expire | (tmr_flag_q & ~int1_rd); // [R11]
         if (g_wr & (reg_sel == `OHS_G_BCAST))
         begin
            bcast_q <= data_i[`OHS_BCAST_BIT]; // [R8]
         end
         if (g_wr & (reg_sel == `OHS_G_TCTL))
         begin
            tctl_q <= data_i[1:0];
         end
         if (g_wr & (reg_sel == `OHS_G_TLO))
         begin
            tload_q[7:0] <= data_i;
         end
         if (tmr_load)
         begin
            tload_q[15:8] <= data_i;
         end
      end
   end

   // General purpose timer
   ohs_timer16 #(
      .W(TMR_W)
   ) u_timer (
      .clk_i(sys_clk_i),
      .rst_n_i(reset_n_i),
      .run_i(tctl_q[`OHS_TCTL_RUN_BIT]),
      .ext_sel_i(tctl_q[`OHS_TCTL_EXT_BIT]),
      .ext_clk_i(timer_ext_clock_i),
      .load_i(tmr_load),
      .load_val_i({data_i, tload_q[7:0]}),
      .count_o(tmr_count),
      .expire_o(tmr_expire)
   );

   // Per channel control registers, prescaler and FIFOs
   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      ohs_byte_t mcr_q, fcr_q;
      logic [1:0] pre_q;
      logic tick_q, rxt_q, txt_q, rxf_q;
      logic [CAW:0] tx_cnt, rx_cnt;
      wire logic tx_v, rx_v, rx_f, tx_clr, rx_clr, fcr_wr, mcr_wr, fifo_on;

      assign mcr_wr = wr_vec[c] & (reg_sel == `OHS_CH_MCR);
      assign fcr_wr = wr_vec[c] & (reg_sel == `OHS_CH_FCR);
      assign tx_clr = soft_rst_q | (fcr_wr & data_i[`OHS_FCR_TXCLR_BIT]); // [R5]
      assign rx_clr = soft_rst_q | (fcr_wr & data_i[`OHS_FCR_RXCLR_BIT]); // [R5]
      assign fifo_on = fcr_q[`OHS_FCR_EN_BIT];
      assign mcr_all[8*c +: 8] = mcr_q;

      // Modem control, FIFO control, prescaler and trigger flags
      always_ff @(posedge sys_clk_i or negedge reset_n_i)
      begin
         if (!reset_n_i)
         begin
            mcr_q <= `OHS_MCR_RST; // [R3]
            fcr_q <= `OHS_FCR_RST; // [R3]
            pre_q <= 2'h0;
            tick_q <= 1'b0;
            rxt_q <= 1'b0;
            txt_q <= 1'b0;
            rxf_q <= 1'b0;
         end
         else
         begin
            if (soft_rst_q)
            begin
               mcr_q <= `OHS_MCR_RST; // [R5]
               fcr_q <= `OHS_FCR_RST; // [R5]
            end
            else
            begin
               mcr_q <= mcr_wr ? data_i : mcr_q;
               fcr_q <= fcr_wr ? data_i : fcr_q;
               if (ir_load_q)
               begin
                  mcr_q[`OHS_MCR_IR_BIT] <= infrared_startup_pin_i; // [R1]
               end
            end
            pre_q <= pre_q + 2'h1;
            tick_q <= mcr_q[`OHS_MCR_PRE_BIT] ? (pre_q == `OHS_PRE_LAST) : 1'b1; // [R13]
            rxt_q <= fifo_on ? (rx_cnt >= ohs_trig(fcr_q[7:6])) : rx_v; // [R12]
            txt_q <= fifo_on ? (tx_cnt <= ohs_trig(fcr_q[5:4])) : ~tx_v; // [R12]
            rxf_q <= rx_f;
         end
      end

      // Transmit FIFO filled by host data writes
      ohs_fifo #(
         .W(8),
         .DEPTH(FIFO_DEPTH),
         .AW(CAW)
      ) u_tx (
         .clk_i(sys_clk_i),
         .rst_n_i(reset_n_i),
         .clr_i(tx_clr),
         .push_i(wr_vec[c] & (reg_sel == `OHS_CH_DATA)), // [R12]
         .wdata_i(data_i),
         .pop_i(tx_pop_i[c]),
         .rdata_o(tx_data_o[8*c +: 8]),
         .valid_o(tx_v),
         .full_o(),
         .count_o(tx_cnt)
      );

      // Receive FIFO drained by host data reads
      ohs_fifo #(
         .W(8),
         .DEPTH(FIFO_DEPTH),
         .AW(CAW)
      ) u_rx (
         .clk_i(sys_clk_i),
         .rst_n_i(reset_n_i),
         .clr_i(rx_clr),
         .push_i(rx_push_i[c]),
         .wdata_i(rx_data_i[8*c +: 8]),
         .pop_i(rd_vec[c] & (reg_sel == `OHS_CH_DATA)), // [R12]
         .rdata_o(rx_head_all[8*c +: 8]),
         .valid_o(rx_v),
         .full_o(rx_f),
         .count_o(rx_cnt)
      );

      assign ir_mode_o[c] = mcr_q[`OHS_MCR_IR_BIT];
      assign baud_tick_o[c] = tick_q;
      assign tx_valid_o[c] = tx_v;
      assign rx_full_o[c] = rxf_q;
      assign rx_trig_o[c] = rxt_q;
      assign tx_trig_o[c] = txt_q;
   end

   // Registered outputs
   assign data_o = data_q;
   assign data_oe_n_o = oe_n_q;
   assign chan_wr_o = chan_wr_q;
   assign chan_rd_o = chan_rd_q;
   assign chan_reg_o = chan_reg_q;
   assign chan_wdata_o = chan_wdata_q;
   assign chan_soft_reset_o = soft_rst_q;
endmodule : ohs_host_select
`default_nettype wire

// ==== design/ohs_pkg.sv ====
// Types shared by the host select block.
// Assumes nothing of its surroundings.
package ohs_pkg;
   typedef logic [7:0] ohs_byte_t;
   typedef enum logic [1:0] {OHS_IDLE, OHS_RD, OHS_WR} ohs_acc_t;
endpackage : ohs_pkg

// ==== design/ohs_timer16.sv ====
// Reloading down counter that runs on the system clock or on an external clock pin.
// Assumes the external clock is slower than half the system clock.
`timescale 1ns/1ps
`default_nettype none
module ohs_timer16 #(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic ext_sel_i,
   input wire logic ext_clk_i,
   input wire logic load_i,
   input wire logic [W-1:0] load_val_i,
   output logic [W-1:0] count_o,
   output logic expire_o
);
   logic ext_s1_q, ext_s2_q, ext_s3_q;
   logic [W-1:0] cnt_q, reload_q;
   logic expire_q;
   wire logic ext_rise, tick;

   // Rising edge of the synchronised external clock; ext_sel_i selects the count source
   assign ext_rise = ext_s2_q & ~ext_s3_q;
   assign tick = run_i & (ext_sel_i ? ext_rise : 1'b1);

   // Synchroniser for the external clock pin
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end
      else
      begin
         ext_s1_q <= ext_clk_i;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // Counter with reload at zero
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= '0;
         reload_q <= '0;
         expire_q <= 1'b0;
      end
      else
      begin
         expire_q <= 1'b0;
         if (load_i)
         begin
            cnt_q <= load_val_i;
            reload_q <= load_val_i;
         end
         else if (tick)
         begin
            cnt_q <= (cnt_q == '0) ? reload_q : cnt_q - 1'b1; // [R14]
            expire_q <= (cnt_q == '0);
         end
      end
   end

   assign count_o = cnt_q;
   assign expire_o = expire_q;
endmodule : ohs_timer16
`default_nettype wire

// ==== test/ohs_host_bfm.sv ====
// Host processor model on the parallel bus, both bus styles.
// Assumes the bench routes the data wire and checks read data.
`timescale 1ns/1ps
`default_nettype none
module ohs_host_bfm (
   input wire logic sys_clk_i,
   input wire logic bus_style_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic [7:0] addr_o,
   output ohs_pkg::ohs_byte_t data_o
);
   import ohs_pkg::*;
   // Bus idle at time zero
   initial
   begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      addr_o = 8'h00;
      data_o = 8'h00;
   end
   // Level across the start edge and the answer edge, then idle
   task automatic access(input logic sel, input logic wr, input logic [7:0] a,
         input ohs_byte_t d);
      @(posedge sys_clk_i);
      cs_n_o <= !sel;
      rd_n_o <= !(bus_style_i && !wr);
      wr_n_o <= !wr;
      addr_o <= a;
      data_o <= wr ? d : ~data_o;
      repeat (2) @(posedge sys_clk_i);
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      data_o <= ~data_o;
   endtask : access
endmodule : ohs_host_bfm
`default_nettype wire

// ==== test/ohs_host_select_assertions.sv ====
// Checker for the host port: decode, strobes, soft reset.
// Assumes a bind into ohs_host_select, all pins on sys_clk_i.
`include "ohs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ohs_host_select_assertions #(
   parameter int NCH = 8
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic bus_style_i,
   input wire logic cs_n_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic [7:0] addr_i,
   input wire ohs_pkg::ohs_byte_t data_i,
   input wire logic data_oe_n_o,
   input wire logic infrared_startup_pin_i,
   input wire logic [NCH-1:0] chan_wr_o,
   input wire logic [NCH-1:0] chan_rd_o,
   input wire logic chan_soft_reset_o,
   input wire logic [NCH-1:0] ir_mode_o
);
   import ohs_pkg::*;
   logic rd_lvl;
   logic wr_lvl;
   logic wr_go;
   logic wr_q;
   logic bc_q;
   logic sr_q;
   // Access levels for both bus styles
   assign rd_lvl = !cs_n_i && (bus_style_i ? !read_strobe_n_i : write_strobe_n_i);
   assign wr_lvl = !cs_n_i && !write_strobe_n_i && !(bus_style_i && !read_strobe_n_i);
   assign wr_go = wr_lvl && !wr_q && addr_i[7];
   // Shadow of broadcast bit and expected soft reset pulse
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wr_q <= 1'b0;
         bc_q <= 1'b0;
         sr_q <= 1'b0;
      end
      else
      begin
         wr_q <= wr_lvl;
         sr_q <= wr_go && addr_i[3:0] == `OHS_G_RESET;
         if (wr_go && addr_i[3:0] == `OHS_G_BCAST)
            bc_q <= data_i[`OHS_BCAST_BIT];
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_cs_ignore: assert property (cs_n_i |=> !(|chan_wr_o) && !(|chan_rd_o)
      && !chan_soft_reset_o) else $error("access taken with chip select high");
   chk_wr_onehot: assert property ($rose(wr_lvl) && !addr_i[7] && !bc_q
      |=> chan_wr_o == (NCH'(1) << $past(addr_i[6:4]))) else $error("bad write decode");
   chk_wr_bcast: assert property ($rose(wr_lvl) && !addr_i[7] && bc_q
      |=> &chan_wr_o) else $error("broadcast write missed a channel");
   chk_rd_onehot: assert property ($rose(rd_lvl) && !addr_i[7]
      |=> chan_rd_o == (NCH'(1) << $past(addr_i[6:4])) && !data_oe_n_o) else $error("bad read");
   chk_global_quiet: assert property (($rose(wr_lvl) || $rose(rd_lvl)) && addr_i[7]
      |=> !(|chan_wr_o) && !(|chan_rd_o)) else $error("global access hit a channel");
   chk_soft_pulse: assert property (chan_soft_reset_o == sr_q)
      else $error("soft reset pulse wrong");
   chk_ir_soft: assert property (chan_soft_reset_o
      |=> ##1 ir_mode_o == {NCH{$past(infrared_startup_pin_i)}}) else $error("ir not sampled");
   chk_oe_release: assert property ($fell(rd_lvl) |=> data_oe_n_o)
      else $error("data still driven after read");
   cover property ($rose(wr_lvl) && bc_q);
   cover property (chan_soft_reset_o);
   cover property ($rose(rd_lvl) && !bus_style_i);
endmodule : ohs_host_select_assertions
bind ohs_host_select ohs_host_select_assertions #(.NCH(NCH)) ohs_host_select_assertions_i (
   .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus_style_i(bus_style_i),
   .cs_n_i(cs_n_i), .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
   .addr_i(addr_i), .data_i(data_i), .data_oe_n_o(data_oe_n_o),
   .infrared_startup_pin_i(infrared_startup_pin_i), .chan_wr_o(chan_wr_o),
   .chan_rd_o(chan_rd_o), .chan_soft_reset_o(chan_soft_reset_o), .ir_mode_o(ir_mode_o));
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench of the host select block with a host model.
// Assumes the checker is bound in; channel cores are driven here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ohs_pkg::*;
   logic sys_clk_i, reset_n_i, bus_style_i, cs_n, rd_n, wr_n, ir_pin, tclk, sleep;
   logic [7:0] addr, irq, tick, tx_pop, rx_push, ir_mode, wr_o, rd_o, tx_valid, tx_trig;
   logic [7:0] n [8];
   logic [15:0] code;
   logic [63:0] crd, tx_data;
   logic [31:0] seed = 32'h00011BE5;
   ohs_byte_t hd, dd, bd, wd, modem_control_reg [8], fb [17];
   logic oe_n, bc;
   ohs_byte_t rq [$];
   ohs_byte_t wq [$];
   ohs_byte_t dq [$];
   int miscompares = 0;
   int n_checks = 0;
   // Data wire: device drives while its enable is low
   assign bd = !oe_n ? dd : hd;
   ohs_host_bfm host_i (.sys_clk_i(sys_clk_i), .bus_style_i(bus_style_i), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .data_o(hd));
   ohs_host_select ohs_host_select_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .bus_style_i(bus_style_i), .cs_n_i(cs_n), .read_strobe_n_i(rd_n),
      .write_strobe_n_i(wr_n), .addr_i(addr), .data_i(bd), .data_o(dd), .data_oe_n_o(oe_n),
      .infrared_startup_pin_i(ir_pin), .timer_ext_clock_i(tclk), .sleep_wake_i(sleep),
      .chan_irq_i(irq), .chan_irq_code_i(code), .chan_rd_data_i(crd), .chan_wr_o(wr_o),
      .chan_rd_o(rd_o), .chan_reg_o(), .chan_wdata_o(wd), .chan_soft_reset_o(),
      .ir_mode_o(ir_mode), .baud_tick_o(tick), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
      .tx_pop_i(tx_pop), .rx_push_i(rx_push), .rx_data_i(crd), .rx_full_o(),
      .tx_trig_o(tx_trig), .rx_trig_o());
   // Clock
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic cmp8(input string nm, input ohs_byte_t e, input ohs_byte_t g);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp8
   task automatic stop_test;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   // Host channel writes note the expected strobe mask and data, global writes nothing; reads note the expected byte
   task automatic w(input logic [7:0] a, input ohs_byte_t v);
      if (!a[7])
      begin
         wq.push_back(bc ? 8'hFF : 8'h01 << a[6:4]);
         dq.push_back(v);
      end
      if (a == 8'h88)
         bc = v[0];
      host_i.access(1'b1, 1'b1, a, v);
   endtask : w
   task automatic r(input logic [7:0] a, input ohs_byte_t e);
      rq.push_back(e);
      host_i.access(1'b1, 1'b0, a, 8'h00);
   endtask : r
   // Result watcher: every read answer and channel write strobe pulse takes the oldest note
   logic oe_q;
   always @(posedge sys_clk_i)
   begin
      if (oe_q === 1'b1 && oe_n === 1'b0)
         cmp8("read_data", rq.size() ? rq.pop_front() : ~dd, dd);
      if (wr_o !== 8'h00)
      begin
         cmp8("chan_wr", wq.size() ? wq.pop_front() : 8'h00, wr_o);
         cmp8("chan_wdata", dq.size() ? dq.pop_front() : ~wd, wd);
      end
      oe_q = oe_n;
   end
   // Watchdog
   initial
   begin
      repeat (50000) @(posedge sys_clk_i);
      miscompares++;
      stop_test();
   end
   initial
   begin
      {reset_n_i, tclk, sleep, irq, code, tx_pop, rx_push, bc} = '0;
      {bus_style_i, ir_pin} = 2'b11;
      crd = {rnd(), rnd()};
      repeat (5) @(posedge sys_clk_i);
      cmp8("oe_rst", 8'h01, {7'h00, oe_n});
      reset_n_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      cmp8("ir_start", 8'hFF, ir_mode);
      ir_pin <= 1'b0;
      for (int c = 0; c < 8; c++)
      begin
         modem_control_reg[c] = 8'(rnd());
         w({1'b0, c[2:0], 4'h4}, modem_control_reg[c]);
         cmp8("ir_mode", {7'h00, modem_control_reg[c][6]}, {7'h00, ir_mode[c]});
         r({1'b0, c[2:0], 4'h4}, modem_control_reg[c]);
         r({1'b0, c[2:0], 4'h2}, crd[8*c +: 8]);
      end
      n = '{default: 8'h00};
      repeat (8) @(posedge sys_clk_i) for (int c = 0; c < 8; c++) n[c] += tick[c];
      for (int c = 0; c < 8; c++) cmp8("ticks", modem_control_reg[c][7] ? 8'h02 : 8'h08, n[c]);
      host_i.access(1'b0, 1'b1, 8'h14, 8'hAA);
      host_i.access(1'b0, 1'b0, 8'h14, 8'h00);
      w(8'h88, 8'h01);
      w(8'h34, 8'h5A);
      for (int c = 0; c < 8; c++) r({1'b0, c[2:0], 4'h4}, 8'h5A);
      w(8'h88, 8'h00);
      irq <= 8'(rnd());
      code <= 16'(rnd());
      sleep <= 1'b1;
      @(posedge sys_clk_i);
      r(8'h80, irq);
      r(8'h81, 8'h02);
      r(8'h82, code[7:0]);
      r(8'h83, code[15:8]);
      w(8'h86, 8'h34);
      w(8'h87, 8'h12);
      r(8'h87, 8'h12);
      w(8'h84, 8'h03);
      repeat (6) @(posedge sys_clk_i) tclk <= ~tclk;
      repeat (4) @(posedge sys_clk_i);
      w(8'h84, 8'h00);
      r(8'h86, 8'h31);
      for (int i = 0; i < 17; i++)
      begin
         fb[i] = 8'(rnd());
         w(8'h10, fb[i]);
      end
      for (int i = 0; i < 16; i++)
      begin
         @(posedge sys_clk_i);
         cmp8("tx_head", fb[i], tx_data[15:8]);
         tx_pop <= 8'h02;
         @(posedge sys_clk_i);
         tx_pop <= 8'h00;
         @(posedge sys_clk_i);
      end
      @(posedge sys_clk_i);
      cmp8("tx_empty", 8'h00, {7'h00, tx_valid[1]});
      cmp8("tx_trig", 8'h01, {7'h00, tx_trig[1]});
      rx_push <= 8'h01;
      @(posedge sys_clk_i);
      rx_push <= 8'h00;
      r(8'h00, crd[7:0]);
      ir_pin <= 1'b1;
      w(8'h89, 8'h00);
      r(8'h04, 8'h40);
      bus_style_i <= 1'b0;
      w(8'h64, 8'h81);
      r(8'h64, 8'h81);
      reset_n_i <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      r(8'h64, 8'h40);
      repeat (4) @(posedge sys_clk_i);
      cmp8("notes_left", 8'h00, 8'(rq.size() + wq.size() + dq.size()));
      stop_test();
   end
endmodule : testbench
`default_nettype wire
